// [calb_cfg.svh]
`ifndef CALB_CFG_SVH
`define CALB_CFG_SVH

// Register addresses
`define CALB_ADDR_AUTOCAL 8'h83
`define CALB_ADDR_CLEAR 8'h84
`define CALB_ADDR_LS0_GAIN 8'hA0
`define CALB_ADDR_LS0_OFFSET 8'hA1
`define CALB_ADDR_LS1_GAIN 8'hA2
`define CALB_ADDR_LS1_OFFSET 8'hA3
`define CALB_ADDR_HS10M_GAIN 8'hA4
`define CALB_ADDR_HS10M_OFFSET 8'hA5
`define CALB_ADDR_HS1M_GAIN 8'hA6
`define CALB_ADDR_HS1M_OFFSET 8'hA7

// Calibration word table layout
`define CALB_WORD_BASE 8'hA0
`define CALB_NUM_WORDS 8
`define CALB_NUM_AUTO 4
`define CALB_IDX_W 3

// Keys, markers and encodings
`define CALB_KEY 32'h4321ABCD
`define CALB_UNCAL 32'h0FFFFFFF
`define CALB_UNITY_GAIN 32'h00004000
`define CALB_HS_OFFSET_BIAS 32'h00004000
`define CALB_ZERO_WORD 32'h00000000
`define CALB_GAIN_SHIFT 14

// Timing
`define CALB_CLK_HZ 10000000
`define CALB_CAL_LIMIT_S 60

`endif

// [calb_pkg.sv]
package calb_pkg;

  // One 32-bit register word
  typedef logic [31:0] calb_word_t;

  // Measurement path selector for the correction stage
  typedef enum logic [1:0] {
    CALB_RANGE_LS_CH0,
    CALB_RANGE_LS_CH1,
    CALB_RANGE_HS_10M,
    CALB_RANGE_HS_1M
  } calb_range_t;

  // Auto calibration sequencer states
  typedef enum logic [1:0] {
    CALB_SEQ_IDLE,
    CALB_SEQ_REQ,
    CALB_SEQ_WAIT
  } calb_seq_t;

endpackage

// [calb_correct.sv]
`timescale 1ns/10ps
`default_nettype none
`include "calb_cfg.svh"

module calb_correct #(
  parameter int SAMPLE_W = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Raw sample
  input wire logic inValid,
  input wire logic signed [SAMPLE_W-1:0] inSample,
  // Selected calibration words
  input wire calb_pkg::calb_word_t gainWord,
  input wire calb_pkg::calb_word_t offsetWord,
  input wire calb_pkg::calb_word_t offsetBias,
  // Corrected sample
  output logic outValid,
  output logic signed [SAMPLE_W-1:0] outSample
);
  import calb_pkg::*;

  if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : gBadWidth
    $error("calb_correct: SAMPLE_W must be 8 to 32");
  end

  logic signed [33:0] offsetEff;
  logic [31:0] gainEff;
  logic signed [33:0] diff_r;
  logic [31:0] gain_r;
  logic valid_r;
  logic signed [66:0] product;

  // Uncalibrated words fall back to unity gain and zero offset
  always_comb begin
    if (offsetWord == `CALB_UNCAL) begin
      offsetEff = '0; // R14
    end else begin
      offsetEff = $signed({2'b00, offsetWord}) - $signed({2'b00, offsetBias}); // R10 R12
    end
    if (gainWord == `CALB_UNCAL) begin
      gainEff = `CALB_UNITY_GAIN; // R13
    end else begin
      gainEff = gainWord;
    end
  end

  // Stage one: remove offset
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      diff_r <= '0;
      gain_r <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= inValid;
      if (inValid) begin
        diff_r <= 34'(inSample) - offsetEff; // R7
        gain_r <= gainEff;
      end
    end
  end

  // Gain is Q18.14, so unity is one shifted by the gain shift
  assign product = 67'(diff_r) * $signed({35'h0, gain_r});

  // Stage two: scale; overflow wraps, callers keep gains sane
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      outSample <= '0;
      outValid <= 1'b0;
    end else begin
      outValid <= valid_r;
      if (valid_r) begin
        outSample <= product[`CALB_GAIN_SHIFT +: SAMPLE_W]; // R6
      end
    end
  end

endmodule
`default_nettype wire

// [calb_auto_seq.sv]
`timescale 1ns/10ps
`default_nettype none
`include "calb_cfg.svh"

module calb_auto_seq #(
  parameter int unsigned CAL_TIMEOUT_CYC = `CALB_CAL_LIMIT_S * `CALB_CLK_HZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Control
  input wire logic start,
  input wire logic weConnected,
  output logic busy,
  output logic failed,
  // Measurement handshake
  output logic measReq,
  output logic [1:0] measIdx,
  input wire logic measDone,
  input wire calb_pkg::calb_word_t measResult,
  // Result write port
  output logic resWr,
  output logic [1:0] resIdx,
  output calb_pkg::calb_word_t resData
);
  import calb_pkg::*;

  if (CAL_TIMEOUT_CYC < 2) begin : gBadTimeout
    $error("calb_auto_seq: CAL_TIMEOUT_CYC must be at least 2");
  end

  localparam logic [31:0] TIMER_LAST = 32'(CAL_TIMEOUT_CYC - 1);
  localparam logic [1:0] LAST_IDX = 2'(`CALB_NUM_AUTO - 1);

  calb_seq_t state_r;
  logic [31:0] timer_r;

  // Sequence walks the four low speed words one measurement at a time
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_r <= CALB_SEQ_IDLE;
      busy <= 1'b0;
      failed <= 1'b0;
      measReq <= 1'b0;
      measIdx <= '0;
      resWr <= 1'b0;
      resIdx <= '0;
      resData <= '0;
    end else begin
      measReq <= 1'b0;
      resWr <= 1'b0;
      case (state_r)
        CALB_SEQ_IDLE: begin
          if (start && weConnected) begin
            failed <= 1'b1; // R2
          end else if (start) begin
            failed <= 1'b0; // R1
            busy <= 1'b1;
            measIdx <= '0;
            state_r <= CALB_SEQ_REQ;
          end
        end
        CALB_SEQ_REQ: begin
          measReq <= 1'b1;
          state_r <= CALB_SEQ_WAIT;
        end
        CALB_SEQ_WAIT: begin
          // Abort keeps results already written; the rest stay as they were
          if (weConnected || timer_r == TIMER_LAST) begin
            failed <= 1'b1; // R2
            busy <= 1'b0;
            state_r <= CALB_SEQ_IDLE;
          end else if (measDone) begin
            resWr <= 1'b1;
            resIdx <= measIdx;
            resData <= measResult;
            if (measIdx == LAST_IDX) begin
              busy <= 1'b0;
              state_r <= CALB_SEQ_IDLE;
            end else begin
              measIdx <= measIdx + 2'h1;
              state_r <= CALB_SEQ_REQ;
            end
          end
        end
        default: begin
          busy <= 1'b0;
          state_r <= CALB_SEQ_IDLE;
        end
      endcase
    end
  end

  // Run time budget, counted over the whole run
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      timer_r <= '0;
    end else if (state_r == CALB_SEQ_IDLE) begin
      timer_r <= '0;
    end else if (timer_r != TIMER_LAST) begin
      timer_r <= timer_r + 32'h1; // R2
    end
  end

endmodule
`default_nettype wire

// [calb_register_bank.sv]
// How it works
// R1: Key at 0x83 starts auto calibration
// R2: Calibration ends within 60 s, WE isolated
// R3: Auto calibration never touches 1M/10M words
// R4: Key at 0x84 clears auto calibrated words; ignored here while a run is busy
// R5: Clear leaves 1M/10M words alone
// R6: Word 0xA0 scales channel 0 low speed
// R7: Word 0xA1 is channel 0 low speed offset
// R8: Words 0xA2/0xA3 calibrate channel 1 low speed
// R9: Word 0xA4 scales high speed 100 nA
// R10: Word 0xA5 offset carries 0x4000 bias
// R11: Word 0xA6 scales high speed 1 uA
// R12: Word 0xA7 offset carries 0x4000 bias
// R13: Uncalibrated gain marker means unity gain
// R14: Uncalibrated offset marker means zero offset
// R15: Host should avoid recalibrating factory units
// R16: Wrong key triggers and clears nothing
// R17: Host writes with S, reads with G
`timescale 1ns/10ps
`default_nettype none
`include "calb_cfg.svh"

module calb_register_bank #(
  parameter int SAMPLE_W = 24,
  parameter int unsigned CAL_TIMEOUT_CYC = `CALB_CAL_LIMIT_S * `CALB_CLK_HZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Decoded set/get register commands
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regAddr,
  input wire calb_pkg::calb_word_t regWrData,
  output calb_pkg::calb_word_t regRdData,
  output logic regAck,
  output logic regErr,
  // Working electrode sense pin and isolation control
  input wire logic weSense,
  output logic weIsolate,
  // Auto calibration status
  output logic calBusy,
  output logic calFailed,
  // Measurement handshake to the analog chain
  output logic measReq,
  output logic [1:0] measIdx,
  input wire logic measDone,
  input wire calb_pkg::calb_word_t measResult,
  // Raw current samples
  input wire logic sampleValid,
  input wire calb_pkg::calb_range_t sampleRange,
  input wire logic signed [SAMPLE_W-1:0] sampleIn,
  // Corrected current samples
  output logic corrValid,
  output logic signed [SAMPLE_W-1:0] corrOut
);
  import calb_pkg::*;

  // Word positions in the table, taken from the register map
  localparam int IDX_LS0_GAIN = `CALB_ADDR_LS0_GAIN - `CALB_WORD_BASE;
  localparam int IDX_LS0_OFFSET = `CALB_ADDR_LS0_OFFSET - `CALB_WORD_BASE;
  localparam int IDX_LS1_GAIN = `CALB_ADDR_LS1_GAIN - `CALB_WORD_BASE;
  localparam int IDX_LS1_OFFSET = `CALB_ADDR_LS1_OFFSET - `CALB_WORD_BASE;
  localparam int IDX_HS10M_GAIN = `CALB_ADDR_HS10M_GAIN - `CALB_WORD_BASE;
  localparam int IDX_HS10M_OFFSET = `CALB_ADDR_HS10M_OFFSET - `CALB_WORD_BASE;
  localparam int IDX_HS1M_GAIN = `CALB_ADDR_HS1M_GAIN - `CALB_WORD_BASE;
  localparam int IDX_HS1M_OFFSET = `CALB_ADDR_HS1M_OFFSET - `CALB_WORD_BASE;

  // Elaboration checks; R3 and R5 hold only while dedicated words sit above the auto ones
  if (SAMPLE_W < 8 || SAMPLE_W > 32) begin : gBadSample
    $error("calb_register_bank: SAMPLE_W must be 8 to 32");
  end
  if (CAL_TIMEOUT_CYC < 2) begin : gBadTimeout
    $error("calb_register_bank: CAL_TIMEOUT_CYC must be at least 2");
  end
  if (`CALB_NUM_WORDS != (1 << `CALB_IDX_W)) begin : gBadTable
    $error("calb_register_bank: word table must fill its index");
  end
  if (IDX_LS1_OFFSET >= `CALB_NUM_AUTO || IDX_HS10M_GAIN < `CALB_NUM_AUTO) begin : gBadSplit
    $error("calb_register_bank: auto and dedicated words overlap");
  end

  // Reset release through two flops
  logic [1:0] rstPipe_r;
  logic rstN;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  assign rstN = rstPipe_r[1];

  // Pin synchroniser for the electrode sense
  logic weSync1_r;
  logic weSync2_r;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      weSync1_r <= 1'b0;
      weSync2_r <= 1'b0;
    end else begin
      weSync1_r <= weSense;
      weSync2_r <= weSync1_r;
    end
  end

  // Address decode
  logic inTable;
  logic [`CALB_IDX_W-1:0] tableIdx;
  logic [7:0] tableOfs;
  logic isAutoCal;
  logic isClear;
  logic keyOk;
  logic anyStb;
  logic mappedAddr;

  assign tableOfs = regAddr - `CALB_WORD_BASE;
  assign inTable = (regAddr >= `CALB_ADDR_LS0_GAIN) && (regAddr <= `CALB_ADDR_HS1M_OFFSET);
  assign tableIdx = tableOfs[`CALB_IDX_W-1:0];
  assign isAutoCal = (regAddr == `CALB_ADDR_AUTOCAL);
  assign isClear = (regAddr == `CALB_ADDR_CLEAR);
  assign keyOk = (regWrData == `CALB_KEY);
  assign anyStb = regWrStb || regRdStb;
  assign mappedAddr = inTable || isAutoCal || isClear;

  // Trigger decode; only the exact key has any effect
  logic seqBusy;
  logic startCal;
  logic clearCal;

  assign startCal = regWrStb && isAutoCal && keyOk; // R1 R16
  // Clear is ignored during a run so a half filled table is never wiped midway
  assign clearCal = regWrStb && isClear && keyOk && !seqBusy; // R4 R16

  // Sequencer signals
  logic seqFailed;
  logic seqMeasReq;
  logic [1:0] seqMeasIdx;
  logic seqResWr;
  logic [1:0] seqResIdx;
  calb_word_t seqResData;

  calb_auto_seq #(
    .CAL_TIMEOUT_CYC(CAL_TIMEOUT_CYC)
  ) uSeq (
    .clock(clock),
    .rstN(rstN),
    .start(startCal),
    .weConnected(weSync2_r),
    .busy(seqBusy),
    .failed(seqFailed),
    .measReq(seqMeasReq),
    .measIdx(seqMeasIdx),
    .measDone(measDone),
    .measResult(measResult),
    .resWr(seqResWr),
    .resIdx(seqResIdx),
    .resData(seqResData)
  );

  // Run status, one flop each; isolation follows the run
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      calBusy <= 1'b0;
      calFailed <= 1'b0;
      weIsolate <= 1'b0;
    end else begin
      calBusy <= seqBusy;
      calFailed <= seqFailed;
      weIsolate <= seqBusy; // R2
    end
  end

  // Measurement handshake, retimed so the outputs leave a flop
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      measReq <= 1'b0;
      measIdx <= '0;
    end else begin
      measReq <= seqMeasReq;
      measIdx <= seqMeasIdx;
    end
  end

  // Calibration word storage
  calb_word_t calWord_r [`CALB_NUM_WORDS];

  // One process per word; sequencer result beats a host write in the same cycle
  for (genvar i = 0; i < `CALB_NUM_WORDS; i++) begin : gWord
    // Auto words are the low speed ones; dedicated words never see the sequencer
    localparam bit IS_AUTO = (i < `CALB_NUM_AUTO);
    logic hostWr;
    logic seqWr;

    // Host and sequencer write enables for this word
    assign hostWr = regWrStb && inTable && (tableIdx == `CALB_IDX_W'(i));
    assign seqWr = IS_AUTO && seqResWr && ({1'b0, seqResIdx} == `CALB_IDX_W'(i)); // R3

    // Reset fills every word with the uncalibrated marker
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        calWord_r[i] <= `CALB_UNCAL;
      end else if (seqWr) begin
        calWord_r[i] <= seqResData; // R1
      end else if (IS_AUTO && clearCal) begin
        calWord_r[i] <= `CALB_UNCAL; // R4 R5
      end else if (hostWr) begin
        calWord_r[i] <= regWrData;
      end
    end
  end

  // Every strobe gets one ack a cycle later; unmapped addresses also flag an error
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      regAck <= 1'b0;
      regErr <= 1'b0;
    end else begin
      regAck <= anyStb;
      regErr <= anyStb && !mappedAddr;
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      regRdData <= `CALB_ZERO_WORD;
    end else if (regRdStb && inTable) begin
      regRdData <= calWord_r[tableIdx];
    end else if (regRdStb) begin
      // Trigger registers are write only and read as zero
      regRdData <= `CALB_ZERO_WORD;
    end
  end

  // Word selection per measurement path
  calb_word_t selGain;
  calb_word_t selOffset;
  calb_word_t selBias;

  always_comb begin
    case (sampleRange)
      CALB_RANGE_LS_CH0: begin
        selGain = calWord_r[IDX_LS0_GAIN]; // R6
        selOffset = calWord_r[IDX_LS0_OFFSET]; // R7
      end
      CALB_RANGE_LS_CH1: begin
        selGain = calWord_r[IDX_LS1_GAIN]; // R8
        selOffset = calWord_r[IDX_LS1_OFFSET]; // R8
      end
      CALB_RANGE_HS_10M: begin
        selGain = calWord_r[IDX_HS10M_GAIN]; // R9
        selOffset = calWord_r[IDX_HS10M_OFFSET]; // R10
      end
      CALB_RANGE_HS_1M: begin
        selGain = calWord_r[IDX_HS1M_GAIN]; // R11
        selOffset = calWord_r[IDX_HS1M_OFFSET]; // R12
      end
      default: begin
        selGain = `CALB_UNCAL;
        selOffset = `CALB_UNCAL;
      end
    endcase
  end

  // High speed offsets carry a bias that the low speed ones lack
  always_comb begin
    case (sampleRange)
      CALB_RANGE_HS_10M: begin
        selBias = `CALB_HS_OFFSET_BIAS; // R10
      end
      CALB_RANGE_HS_1M: begin
        selBias = `CALB_HS_OFFSET_BIAS; // R12
      end
      default: begin
        selBias = `CALB_ZERO_WORD;
      end
    endcase
  end

  // Correction pipeline; two cycles from sample to result
  calb_correct #(
    .SAMPLE_W(SAMPLE_W)
  ) uCorrect (
    .clock(clock),
    .rstN(rstN),
    .inValid(sampleValid),
    .inSample(sampleIn),
    .gainWord(selGain),
    .offsetWord(selOffset),
    .offsetBias(selBias),
    .outValid(corrValid),
    .outSample(corrOut)
  );

endmodule
`default_nettype wire

// [calb_register_bank_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "calb_cfg.svh"
module calb_register_bank_properties #(
  parameter int unsigned CAL_TIMEOUT_CYC = 60
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regAddr,
  input wire calb_pkg::calb_word_t regWrData,
  input wire logic regAck,
  input wire logic regErr,
  // Calibration and samples
  input wire logic weSense,
  input wire logic weIsolate,
  input wire logic calBusy,
  input wire logic calFailed,
  input wire logic measReq,
  input wire logic [1:0] measIdx,
  input wire logic measDone,
  input wire logic sampleValid,
  input wire logic corrValid
);
  import calb_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic anyStb;
  logic mapped;
  logic startWr;
  logic [31:0] busyCnt_r;
  // Decode shared by several checks
  assign anyStb = regWrStb | regRdStb;
  assign mapped = regAddr inside {8'h83, 8'h84} || regAddr[7:3] == 5'h14;
  assign startWr = regWrStb && regAddr == 8'h83 && regWrData == `CALB_KEY;
  // Run length, so a run that never ends is caught
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busyCnt_r <= 32'h0;
    end else begin
      busyCnt_r <= calBusy ? busyCnt_r + 32'h1 : 32'h0;
    end
  end
  sequence s_result;
    measDone && calBusy;
  endsequence
  sequence s_wrongKey;
    regWrStb && regAddr == 8'h83 && !startWr && !calBusy && !$past(regWrStb);
  endsequence
  a_ack_exact:
    assert property (regAck == $past(anyStb)) else $error("ack not one cycle after strobe");
  a_err_unmapped:
    assert property (anyStb |=> regErr == !$past(mapped)) else $error("error flag wrong");
  a_start_runs:
    assert property (startWr && !calBusy |-> ##2 (calBusy || calFailed)) else $error("key did not start");
  a_wrong_key:
    assert property (s_wrongKey |-> ##2 !calBusy) else $error("wrong key started a run");
  a_first_meas:
    assert property ($rose(calBusy) |-> ##1 measReq && measIdx == 2'h0) else $error("first request late");
  a_meas_next:
    assert property (s_result |-> ##3 (measReq || !calBusy)) else $error("next request missing");
  a_iso_busy:
    assert property (weIsolate == calBusy) else $error("isolation not with run");
  a_idle_quiet:
    assert property (!calBusy |-> !measReq) else $error("request while idle");
  a_run_bounded:
    assert property (busyCnt_r <= CAL_TIMEOUT_CYC + 2) else $error("run too long");
  a_abort_connect:
    assert property (weSense [*3] |-> ##[0:4] !calBusy) else $error("no abort on connect");
  a_corr_latency:
    assert property (corrValid == $past(sampleValid, 2)) else $error("corrected sample late");
endmodule
`default_nettype wire

// [calb_meas_model.sv]
`timescale 1ns/10ps
`default_nettype none
module calb_meas_model (
  // Clock and answer mode
  input wire logic clock,
  input wire logic slow,
  input wire logic mute,
  // Measurement handshake
  input wire logic measReq,
  input wire logic [1:0] measIdx,
  output logic measDone,
  output calb_pkg::calb_word_t measResult
);
  import calb_pkg::*;
  int waitCnt = -1;
  logic [1:0] idx = 2'h0;
  initial measDone = 1'b0;
  initial measResult = 32'h0;
  // One answer per request unless muted; result line toggles when not valid
  always @(posedge clock) begin
    measDone <= 1'b0;
    measResult <= ~measResult;
    if (measReq && !mute) begin
      idx <= measIdx;
      waitCnt <= slow ? 5 : 0;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end else if (waitCnt == 0) begin
      measDone <= 1'b1;
      measResult <= 32'h12345670 + 32'(idx);
      waitCnt <= -1;
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "calb_cfg.svh"
module tb_top;
  import calb_pkg::*;
  localparam int unsigned TMO = 60;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [7:0] regAddr = 8'h00;
  calb_word_t regWrData = 32'h0;
  logic weSense = 1'b0;
  logic sampleValid = 1'b0;
  calb_range_t sampleRange = CALB_RANGE_LS_CH0;
  logic signed [23:0] sampleIn = 24'sh0;
  logic slow = 1'b0;
  logic mute = 1'b0;
  calb_word_t regRdData, measResult;
  logic regAck, regErr, weIsolate, calBusy, calFailed, measReq, measDone, corrValid;
  logic [1:0] measIdx;
  logic signed [23:0] corrOut;
  int nFail = 0;
  int compares = 0;
  int cycles = 0;
  calb_word_t hs [4] = '{32'h8000, 32'h4003, 32'hC000, 32'h3FFE};
  // Clock, 100 ns period
  always #50 clock = ~clock;
  calb_register_bank #(.CAL_TIMEOUT_CYC(TMO)) dut_u (.clock, .nrst, .regWrStb, .regRdStb, .regAddr,
    .regWrData, .regRdData, .regAck, .regErr, .weSense, .weIsolate, .calBusy, .calFailed, .measReq,
    .measIdx, .measDone, .measResult, .sampleValid, .sampleRange, .sampleIn, .corrValid, .corrOut);
  calb_meas_model mdl_u (.clock, .slow, .mute, .measReq, .measIdx, .measDone, .measResult);
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  // One access; a fresh edge first, so strobes never change twice at once
  task automatic acc(input logic wr, input logic [7:0] a, input calb_word_t d);
    cyc(1);
    regWrStb = wr;
    regRdStb = !wr;
    regAddr = a;
    regWrData = d;
    cyc(1);
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    chk("ack", 1, regAck);
    chk("err", !(a inside {8'h83, 8'h84} || a[7:3] == 5'h14), regErr);
  endtask
  task automatic rd(input logic [7:0] a, input calb_word_t e);
    acc(1'b0, a, 32'h0);
    chk("rdata", e, regRdData);
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    while (calBusy !== 1'b0 && n < 300) begin
      cyc(1);
      n++;
    end
    chk("busy", 0, calBusy);
  endtask
  task automatic smp(input calb_range_t r, input logic signed [23:0] s, input logic signed [23:0] e);
    cyc(1);
    sampleValid = 1'b1;
    sampleRange = r;
    sampleIn = s;
    cyc(1);
    sampleValid = 1'b0;
    cyc(1);
    chk("valid", 1, corrValid);
    chk("corr", 32'(e), 32'(corrOut));
  endtask
  task automatic t_reset;
    for (int k = 0; k < 8; k++) begin
      rd(8'hA0 + 8'(k), `CALB_UNCAL);
    end
    rd(8'h83, 32'h0);
    rd(8'h84, 32'h0);
    acc(1'b0, 8'h85, 32'h0);
  endtask
  task automatic t_words;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'hA4 + 8'(k), hs[k]);
      rd(8'hA4 + 8'(k), hs[k]);
    end
    acc(1'b1, 8'h85, 32'h1);
  endtask
  task automatic t_cal(input logic s);
    slow = s;
    acc(1'b1, 8'h83, `CALB_KEY);
    cyc(1);
    chk("busy", 1, calBusy);
    chk("isolate", 1, weIsolate);
    waitIdle();
    chk("failed", 0, calFailed);
    for (int k = 0; k < 4; k++) begin
      rd(8'hA0 + 8'(k), 32'h12345670 + 32'(k));
      rd(8'hA4 + 8'(k), hs[k]);
    end
  endtask
  // Wrong keys, the complement and a near miss, must leave everything alone
  task automatic t_wrong;
    acc(1'b1, 8'h83, ~`CALB_KEY);
    cyc(2);
    chk("busy", 0, calBusy);
    acc(1'b1, 8'h84, 32'h4321ABCC);
    rd(8'hA0, 32'h12345670);
  endtask
  task automatic t_clear;
    acc(1'b1, 8'h84, `CALB_KEY);
    for (int k = 0; k < 4; k++) begin
      rd(8'hA0 + 8'(k), `CALB_UNCAL);
      rd(8'hA4 + 8'(k), hs[k]);
    end
  endtask
  // Expected: ((sample - offset) * gain) >>> 14
  task automatic t_corr;
    smp(CALB_RANGE_LS_CH0, 24'sd100, 24'sd100);
    acc(1'b1, 8'hA0, 32'h8000);
    acc(1'b1, 8'hA1, 32'h5);
    smp(CALB_RANGE_LS_CH0, 24'sd100, 24'sd190);
    acc(1'b1, 8'hA2, 32'h2000);
    acc(1'b1, 8'hA3, 32'h4);
    smp(CALB_RANGE_LS_CH1, 24'sd100, 24'sd48);
    smp(CALB_RANGE_HS_10M, 24'sd100, 24'sd194);
    smp(CALB_RANGE_HS_1M, 24'sd100, 24'sd306);
  endtask
  // Refusal, abort on connection, abort on silence
  task automatic t_refuse;
    weSense = 1'b1;
    cyc(3);
    acc(1'b1, 8'h83, `CALB_KEY);
    cyc(1);
    chk("busy", 0, calBusy);
    chk("failed", 1, calFailed);
    weSense = 1'b0;
    cyc(3);
    acc(1'b1, 8'h83, `CALB_KEY);
    cyc(4);
    weSense = 1'b1;
    waitIdle();
    chk("failed", 1, calFailed);
    weSense = 1'b0;
    mute = 1'b1;
    cyc(3);
    acc(1'b1, 8'h83, `CALB_KEY);
    waitIdle();
    chk("failed", 1, calFailed);
  endtask
  // Watchdog against a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    #10;
    nrst = 1'b1;
    cyc(3);
    t_reset();
    t_words();
    t_cal(1'b0);
    t_wrong();
    // Bench unit carries no factory calibration, so a rerun is fair
    t_cal(1'b1);
    t_clear();
    t_corr();
    t_refuse();
    print_verdict();
  end
endmodule
bind calb_register_bank calb_register_bank_properties #(.CAL_TIMEOUT_CYC(CAL_TIMEOUT_CYC)) props_u (.clock, .nrst,
  .regWrStb, .regRdStb, .regAddr, .regWrData, .regAck, .regErr, .weSense, .weIsolate, .calBusy, .calFailed,
  .measReq, .measIdx, .measDone, .sampleValid, .corrValid);
`default_nettype wire
